/* File: dv/cpe_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cpe_model
(
    input wire logic clock,
    output logic rx_sig_valid,
    output e1_cas_pkg::sig_word_t rx_sig
);
import e1_cas_pkg::*;
initial begin
    rx_sig_valid = 1'b0;
    rx_sig = '0;
end
// speaks only when asked, so the bench can start a call inside the guard
task send(input logic [4:0] ch, input logic [3:0] cd, input int lag);
    repeat (lag + 1) @(posedge clock);
    rx_sig_valid <= 1'b1;
    rx_sig <= {ch, cd};
    @(posedge clock);
    rx_sig_valid <= 1'b0;
    rx_sig <= ~{ch, cd};
endtask
endmodule // cpe_model
`default_nettype wire

/* File: dv/e1_cas_signaling_alarm_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module e1_cas_signaling_alarm_bench;
import e1_cas_pkg::*;
localparam int MSC = 10;
logic clock, reset_n, hsel, hwrite, hreadyout, hresp, rx_sig_valid, rx_silence, alarm_contact;
logic fbit_valid, fbit_error, frame_found, line_bit_valid, line_bit, slip_alarm;
logic maintenance_indicator, ber_level1, ber_level2, line_processing;
logic [31:0] haddr, hwdata, hrdata, rd;
logic [1:0] htrans;
logic [2:0] hsize;
logic [29:0] switch_offhook;
sig_word_t rx_sig, tx_sig;
wire logic hready;
int fail_count, n_tests;
assign hready = hreadyout;
e1_cas_signaling_alarm #(.MS_CYCLES(MSC)) e1_cas_signaling_alarm_i (.clock, .reset_n, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
    .rx_sig_valid, .rx_sig, .tx_sig, .switch_offhook, .fbit_valid, .fbit_error, .frame_found,
    .line_bit_valid, .line_bit, .ber_level1, .ber_level2, .slip_alarm,
    .reframe_start(), .resync_start(), .rx_silence, .alarm_contact, .maintenance_indicator,
    .yellow_alarm(), .line_processing);
cpe_model cpe_model_i (.clock, .rx_sig_valid, .rx_sig);
task end_of_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
endtask
task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
        fail_count++;
        $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
endtask
task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clock); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    rd = hrdata;
endtask
task st;
    bus(0, ADDR_STATUS, 0);
endtask
// sampled at negedge, clear of updates
task txc(input logic [4:0] c, input logic [3:0] e, input string what);
    repeat (2) @(posedge clock);
    repeat (31) begin
        @(negedge clock);
        if (tx_sig.chan === c) break;
    end
    chk(32'(tx_sig.code), 32'(e), what);
endtask
task t_regs;
    bus(0, ADDR_CTRL, 0);
    chk(rd, 32'(CTRL_RESET), "ctrl");
    bus(1, ADDR_DISC, 32'd4001);
    bus(0, ADDR_DISC, 0);
    chk(rd, 32'd1000, "disc");
    bus(0, 8'h40, 0);
    chk(rd, 32'h0, "unmapped");
    bus(1, ADDR_CODE, 32'h295);
    bus(1, ADDR_CODE, 32'h390);
    bus(0, ADDR_CODE, 0);
    chk(rd & 32'h10f, 32'h105, "code");
    bus(1, ADDR_CODE, 32'h406);
    ber_level1 <= 1'b1;
    st;
    ber_level1 <= 1'b0;
    chk(rd & 32'h3, 32'h1, "ber level");
    bus(1, ADDR_CMD, 32'h2);
    $display("t_regs done");
endtask
task t_out;
    cpe_model_i.send(5'd3, 4'h5, 0);
    bus(0, ADDR_HOOK, 0);
    chk(rd & 32'h8, 32'h8, "seize hook");
    txc(5'd3, 4'h1, "seize ack");
    txc(5'd4, 4'h6, "idle send");
    bus(1, ADDR_CALL, 32'h303);
    txc(5'd3, 4'ha, "answered");
    $display("t_out done");
endtask
task t_inc;
    bus(1, ADDR_DISC, 32'd6);
    bus(1, ADDR_GUARD, 32'd5);
    bus(1, ADDR_CALL, 32'h107);
    txc(5'd7, 4'h0, "ring on");
    bus(1, ADDR_CALL, 32'h207);
    txc(5'd7, 4'h5, "ring off");
    cpe_model_i.send(5'd7, 4'hf, 3);
    bus(0, ADDR_HOOK, 0);
    chk(rd & 32'h80, 32'h80, "answer hook");
    bus(1, ADDR_CALL, 32'h407);
    cpe_model_i.send(5'd7, 4'hf, 0);
    txc(5'd7, 4'hf, "disc hold");
    repeat (45) @(posedge clock);
    cpe_model_i.send(5'd7, 4'h5, 0);
    bus(0, ADDR_HOOK, 0);
    chk(rd & 32'h80, 32'h0, "guard");
    repeat (60) @(posedge clock);
    txc(5'd7, 4'h6, "idle again");
    $display("t_inc done");
endtask
task t_los;
    @(posedge clock);
    line_bit_valid <= 1'b1;
    repeat (260) @(posedge clock);
    st;
    chk(rd & 32'hc0, 32'h40, "los");
    repeat (2000 * MSC + 100) @(posedge clock);
    st;
    chk(rd & 32'h7fc3, 32'h1c2, "line alarm");
    chk({rx_silence, alarm_contact, line_processing, hresp}, 32'he, "mute");
    line_bit <= 1'b1;
    repeat (1000 * MSC) @(posedge clock);
    st;
    chk(rd & 32'h80, 32'h80, "alarm held");
    repeat (1100 * MSC) @(posedge clock);
    st;
    chk(rd & 32'h83, 32'h0, "self clear");
    bus(1, ADDR_CMD, 32'h2);
    st;
    chk(rd & 32'h7f00, 32'h0, "log clear");
    line_bit_valid <= 1'b0;
    $display("t_los done");
endtask
task t_oof;
    @(posedge clock);
    fbit_valid <= 1'b1;
    fbit_error <= 1'b1;
    slip_alarm <= 1'b1;
    repeat (3) @(posedge clock);
    fbit_valid <= 1'b0;
    repeat (4) @(posedge clock);
    slip_alarm <= 1'b0;
    st;
    chk(rd & 32'h23, 32'h22, "oof");
    chk(32'(rx_silence), 32'h1, "oof mute");
    bus(1, ADDR_CTRL, 32'h12);
    st;
    chk({rd[1:0], alarm_contact, maintenance_indicator}, 32'h9, "disabled");
    bus(1, ADDR_CTRL, 32'h13);
    bus(1, ADDR_CMD, 32'h1);
    st;
    chk(rd & 32'h3, 32'h2, "re-raised");
    frame_found <= 1'b1;
    @(posedge clock);
    frame_found <= 1'b0;
    st;
    chk(rd & 32'h20, 32'h0, "reframed");
    $display("t_oof done");
endtask
initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
end
initial begin
    repeat (60000) @(posedge clock);
    fail_count++;
    end_of_test;
end
initial begin
    {reset_n, hsel, hwrite, fbit_valid, fbit_error, frame_found} = '0;
    {line_bit_valid, line_bit, slip_alarm, ber_level1, ber_level2, haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    fail_count = 0;
    n_tests = 0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    t_regs;
    t_out;
    t_inc;
    t_los;
    t_oof;
    end_of_test;
end
endmodule // e1_cas_signaling_alarm_bench
`default_nettype wire

/* File: dv/e1_cas_signaling_alarm_props.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// port checks
// ----
module e1_cas_props
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic fbit_valid,
    input wire logic fbit_error,
    input wire logic line_bit_valid,
    input wire logic line_bit,
    input wire logic slip_alarm,
    input wire e1_cas_pkg::sig_word_t tx_sig,
    input wire logic reframe_start,
    input wire logic resync_start,
    input wire logic rx_silence,
    input wire logic alarm_contact,
    input wire logic maintenance_indicator,
    input wire logic yellow_alarm
);
import e1_cas_pkg::*;
default clocking @(posedge clock);
endclocking
default disable iff (!reset_n);
property p_oof_src; reframe_start |-> $past(fbit_valid && fbit_error); endproperty
a_oof_src: assert property (p_oof_src) else $error("bad reframe");
property p_oof_pulse; reframe_start |=> !reframe_start; endproperty
a_oof_pulse: assert property (p_oof_pulse) else $error("long reframe");
property p_oof_mute; reframe_start |-> ##[0:2] rx_silence; endproperty
a_oof_mute: assert property (p_oof_mute) else $error("no silence");
property p_los_src; resync_start |-> $past(line_bit_valid && !line_bit); endproperty
a_los_src: assert property (p_los_src) else $error("bad resync");
property p_los_pulse; resync_start |=> !resync_start; endproperty
a_los_pulse: assert property (p_los_pulse) else $error("long resync");
property p_scan;
    $past(reset_n) |=> tx_sig.chan == ($past(tx_sig.chan) == 5'd29 ? 5'd0
        : $past(tx_sig.chan) + 5'd1);
endproperty
a_scan: assert property (p_scan) else $error("scan out of order");
property p_maintenance_indicator; yellow_alarm |-> alarm_contact && maintenance_indicator; endproperty
a_maintenance_indicator: assert property (p_maintenance_indicator) else $error("yellow while disabled");
property p_slip; slip_alarm [*3] |-> alarm_contact || maintenance_indicator; endproperty
a_slip: assert property (p_slip) else $error("slip not raised");
endmodule // e1_cas_props
bind e1_cas_signaling_alarm e1_cas_props e1_cas_props_i (.clock, .reset_n, .fbit_valid,
    .fbit_error, .line_bit_valid, .line_bit, .slip_alarm, .tx_sig, .reframe_start,
    .resync_start, .rx_silence, .alarm_contact, .maintenance_indicator, .yellow_alarm);
`default_nettype wire

/* File: include/e1_cas_pkg.sv */
package e1_cas_pkg;
    // ----
    // sizes and timing
    // ----
    localparam int CHANNELS = 30;
    localparam int CLK_PERIOD_NS = 40;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam int SEC_MS = 1000;
    localparam int ALARM_HOLD_S = 2;
    localparam logic [10:0] ALARM_HOLD_MS = 11'(ALARM_HOLD_S * SEC_MS);
    localparam logic [11:0] DISC_MAX_MS = 12'd4000;
    localparam logic [11:0] DISC_RESET_MS = 12'd1000;
    localparam logic [10:0] GUARD_MAX_MS = 11'd2000;
    localparam logic [10:0] GUARD_RESET_MS = 11'h000;
    localparam logic [1:0] OOF_ERR_BITS = 2'd3;
    localparam logic [7:0] LOS_ZERO_BITS = 8'hff;
    localparam int LOG_DEPTH = 100;
    localparam logic [2:0] CODE_CNT_AB = 3'h2;
    localparam logic [2:0] CODE_CNT_ABCD = 3'h4;
    // ----
    // register map (byte addresses)
    // ----
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CODE = 8'h04;
    localparam logic [7:0] ADDR_DISC = 8'h08;
    localparam logic [7:0] ADDR_GUARD = 8'h0c;
    localparam logic [7:0] ADDR_CMD = 8'h10;
    localparam logic [7:0] ADDR_CALL = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_HOOK = 8'h1c;
    localparam logic [7:0] ADDR_LOG_SEL = 8'h20;
    localparam logic [7:0] ADDR_LOG_DATA = 8'h24;
    localparam logic [7:0] ADDR_TIME = 8'h28;
    // control bits
    localparam int CTRL_ALARM_EN = 0;
    localparam int CTRL_SELF_CLEAR = 1;
    localparam int CTRL_BLK_OFFHOOK = 2;
    localparam int CTRL_BLK_EN = 3;
    localparam int CTRL_SEIZE_ACK_EN = 4;
    localparam int CTRL_LOOP_START = 5;
    localparam logic [5:0] CTRL_RESET = 6'h13;
    localparam int CMD_CLR_ALARM = 0;
    localparam int CMD_CLR_LOG = 1;
    // ----
    // signaling code table
    // ----
    typedef enum logic [3:0] {
        IDLE_TX, IDLE_RX, BLK_RX, RING_ON_TX, RING_OFF_TX, INC_OFFHOOK_RX,
        INC_CONN_TX, INC_FDISC_TX, INC_DISC_RX, SEIZE_RX, SEIZE_ACK_TX,
        DIAL_MAKE_RX, DIAL_BREAK_RX, ANSWERED_TX, OUT_DISC_RX, OUT_FDISC_TX
    } code_idx_t;
    // entry 0 in the low nibble
    localparam logic [63:0] CODE_RESET = 64'hf5a1_f1f5_f5f5_0500;
    typedef enum logic [2:0] {
        CALL_NONE, CALL_RING_ON, CALL_RING_OFF, CALL_FAR_ANSWER, CALL_FAR_RELEASE
    } call_cmd_t;
    typedef enum logic [1:0] {
        LOG_NONE, LOG_LEVEL1, LOG_LEVEL2, LOG_CLEARED
    } log_kind_t;
    typedef struct packed {
        logic [4:0] chan;
        logic [3:0] code;
    } sig_word_t;
    typedef struct packed {
        log_kind_t kind;
        logic [23:0] stamp;
    } log_entry_t;
endpackage

/* File: verilog/e1_cas_signaling_alarm.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1: code has two or four bits
// R2: two-bit code copied to CD
// R3: idle channel sends idle code
// R4: idle receive code means idle
// R5: optional blocking code, switch picks hook
// R6: ringer-on and ringer-off codes
// R7: off-hook answered with connected code
// R8: far release sends disconnect code
// R9: CPE disconnect codes end calls
// R10: seize acknowledged unless disabled
// R11: dial make and break tracked
// R12: far answer sends answered code
// R13: far disconnect held, loop start skips
// R14: release guard ignores new calls
// R15: CPE waits out release guard
// R16: three framing errors mean out of frame
// R17: 255 zeros mean loss of signal
// R18: long loss raises level two
// R19: long unframed ones is AIS
// R20: two clean seconds clear line alarm
// R21: bit errors any level, others two
// R22: disable drops contacts, lights indicator
// R23: clear command, re-raised if persisting
// R24: log of last 100 alarms
// R25: self clear when condition gone
// R26: one state machine per channel
module e1_cas_signaling_alarm #(
    parameter int CHANNELS = e1_cas_pkg::CHANNELS,
    parameter int MS_CYCLES = e1_cas_pkg::MS_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // signaling from and to the cpe
    input wire logic rx_sig_valid,
    input wire e1_cas_pkg::sig_word_t rx_sig,
    output e1_cas_pkg::sig_word_t tx_sig,
    output logic [CHANNELS-1:0] switch_offhook,
    // line condition inputs
    input wire logic fbit_valid,
    input wire logic fbit_error,
    input wire logic frame_found,
    input wire logic line_bit_valid,
    input wire logic line_bit,
    input wire logic ber_level1,
    input wire logic ber_level2,
    input wire logic slip_alarm,
    // line and alarm outputs
    output logic reframe_start,
    output logic resync_start,
    output logic rx_silence,
    output logic alarm_contact,
    output logic maintenance_indicator,
    output logic yellow_alarm,
    output logic line_processing
);
    import e1_cas_pkg::*;

    typedef enum {
        CH_IDLE, CH_GUARD, CH_BLOCKED, CH_RING, CH_INC_CONN,
        CH_SEIZED, CH_ANSWERED, CH_FAR_DISC
    } ch_state_t;

    // ----
    // time base
    // ----
    logic [$clog2(MS_CYCLES)-1:0] ms_div;
    logic [9:0] sec_div;
    logic ms_tick;
    logic sec_tick;
    logic [23:0] seconds;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ms_div <= '0;
            ms_tick <= 1'b0;
        end else begin
            ms_tick <= (ms_div == $bits(ms_div)'(MS_CYCLES - 1));
            if (ms_div == $bits(ms_div)'(MS_CYCLES - 1)) ms_div <= '0;
            else ms_div <= ms_div + 1'b1;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sec_div <= '0;
            sec_tick <= 1'b0;
        end else begin
            sec_tick <= ms_tick && (sec_div == 10'(SEC_MS - 1));
            if (ms_tick) begin
                if (sec_div == 10'(SEC_MS - 1)) sec_div <= '0;
                else sec_div <= sec_div + 1'b1;
            end
        end
    end

    // ----
    // register bus
    // ----
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [5:0] ctrl;
    logic [3:0] codes [16];
    code_idx_t code_sel;
    logic code_rejected;
    logic [11:0] disc_ms;
    logic [10:0] guard_ms;
    logic [6:0] log_sel;
    logic [31:0] rd_mux;
    logic wr_ctrl, wr_code, wr_cmd, wr_call;
    logic clear_alarm, clear_log;
    logic [1:0] alarm_lvl;
    logic los, oof, line_alarm;
    logic [6:0] log_count;
    log_entry_t log_mem [LOG_DEPTH];

    assign wr_ctrl = wr_pend && wr_addr == ADDR_CTRL;
    assign wr_code = wr_pend && wr_addr == ADDR_CODE;
    assign wr_cmd = wr_pend && wr_addr == ADDR_CMD;
    assign wr_call = wr_pend && wr_addr == ADDR_CALL;
    assign clear_alarm = wr_cmd && hwdata[CMD_CLR_ALARM];
    assign clear_log = wr_cmd && hwdata[CMD_CLR_LOG];

    // zero wait: read data latched in the address phase
    always_comb begin
        rd_mux = '0;
        unique case (haddr[7:0])
            ADDR_CTRL: rd_mux = {26'h0, ctrl};
            ADDR_CODE: rd_mux = {23'h0, code_rejected, code_sel, codes[code_sel]};
            ADDR_DISC: rd_mux = {20'h0, disc_ms};
            ADDR_GUARD: rd_mux = {21'h0, guard_ms};
            ADDR_STATUS: rd_mux = {17'h0, log_count, line_alarm, los, oof, 3'h0,
                alarm_lvl};
            ADDR_HOOK: rd_mux = 32'(switch_offhook);
            ADDR_LOG_SEL: rd_mux = {25'h0, log_sel};
            ADDR_LOG_DATA: rd_mux = (log_sel < 7'(LOG_DEPTH))
                ? 32'(log_mem[log_sel]) : 32'h0;
            ADDR_TIME: rd_mux = {8'h0, seconds};
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
            hrdata <= '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend <= hsel && htrans[1] && hready && hwrite;
            if (hsel && htrans[1] && hready) begin
                wr_addr <= haddr[7:0];
                if (!hwrite) hrdata <= rd_mux;
            end
        end
    end

    // configuration registers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ctrl <= CTRL_RESET;
            disc_ms <= DISC_RESET_MS;
            guard_ms <= GUARD_RESET_MS;
            log_sel <= '0;
        end else if (wr_pend) begin
            if (wr_ctrl) ctrl <= hwdata[5:0];
            if (wr_addr == ADDR_DISC && hwdata[11:0] <= DISC_MAX_MS) disc_ms <= hwdata[11:0];
            if (wr_addr == ADDR_GUARD && hwdata[10:0] <= GUARD_MAX_MS) begin
                guard_ms <= hwdata[10:0];
            end
            if (wr_addr == ADDR_LOG_SEL) log_sel <= hwdata[6:0];
        end
    end

    // code table: data [3:0], entry [7:4], bit count [10:8]
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 16; i++) codes[i] <= CODE_RESET[i*4 +: 4];
            code_sel <= IDLE_TX;
            code_rejected <= 1'b0;
        end else if (wr_code) begin
            code_sel <= code_idx_t'(hwdata[7:4]);
            code_rejected <= 1'b0;
            if (hwdata[10:8] == CODE_CNT_AB) begin
                codes[hwdata[7:4]] <= {hwdata[1:0], hwdata[1:0]}; // [R2] [R1]
            end else if (hwdata[10:8] == CODE_CNT_ABCD) begin
                codes[hwdata[7:4]] <= hwdata[3:0]; // [R1]
            end else begin
                code_rejected <= 1'b1; // [R1]
            end
        end
    end

    // ----
    // channel signaling
    // ----
    call_cmd_t call_cmd;
    logic [3:0] tx_code_v [CHANNELS];
    logic [CHANNELS-1:0] hook_v;
    logic [4:0] tx_chan;

    assign call_cmd = call_cmd_t'(hwdata[10:8]);

    function automatic logic code_hit(code_idx_t i);
        return rx_sig.code == codes[i]; // [R26]
    endfunction

    for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
        ch_state_t st;
        logic [11:0] tmr;
        logic inc, ring_on, brk;
        logic rx, cmd;
        ch_state_t end_state;

        assign rx = rx_sig_valid && rx_sig.chan == 5'(g);
        assign cmd = wr_call && hwdata[4:0] == 5'(g);
        assign end_state = (guard_ms != 11'h0) ? CH_GUARD : CH_IDLE; // [R14]

        always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
                st <= CH_IDLE;
                tmr <= '0;
                inc <= 1'b0;
                ring_on <= 1'b0;
                brk <= 1'b0;
            end else begin
                if (ms_tick && tmr != 12'h0) tmr <= tmr - 12'h001;
                unique case (st)
                    CH_IDLE: begin
                        if (rx && code_hit(SEIZE_RX)) begin
                            st <= CH_SEIZED;
                            inc <= 1'b0;
                            brk <= 1'b0;
                        end else if (rx && ctrl[CTRL_BLK_EN] && code_hit(BLK_RX)) begin
                            st <= CH_BLOCKED; // [R5]
                        end else if (cmd && call_cmd == CALL_RING_ON) begin
                            st <= CH_RING;
                            inc <= 1'b1;
                            ring_on <= 1'b1;
                        end
                    end
                    // guard: new calls ignored
                    CH_GUARD: if (tmr == 12'h0) st <= CH_IDLE; // [R14] [R15]
                    CH_BLOCKED: if (rx && code_hit(IDLE_RX)) st <= CH_IDLE; // [R4]
                    CH_RING: begin
                        if (rx && code_hit(INC_OFFHOOK_RX)) st <= CH_INC_CONN; // [R7]
                        else if (cmd && call_cmd == CALL_FAR_RELEASE) begin
                            st <= end_state;
                            tmr <= {1'b0, guard_ms};
                        end else if (cmd && call_cmd == CALL_RING_OFF) ring_on <= 1'b0;
                        else if (cmd && call_cmd == CALL_RING_ON) ring_on <= 1'b1; // [R6]
                    end
                    CH_SEIZED, CH_ANSWERED, CH_INC_CONN: begin
                        if (rx && code_hit(DIAL_MAKE_RX)) brk <= 1'b0; // [R11]
                        else if (rx && code_hit(DIAL_BREAK_RX)) brk <= 1'b1; // [R11]
                        if (rx && code_hit(inc ? INC_DISC_RX : OUT_DISC_RX)) begin
                            st <= end_state; // [R9]
                            tmr <= {1'b0, guard_ms};
                        end else if (cmd && call_cmd == CALL_FAR_RELEASE) begin
                            // loop start has no disconnect supervision
                            st <= ctrl[CTRL_LOOP_START] ? end_state : CH_FAR_DISC; // [R13]
                            tmr <= ctrl[CTRL_LOOP_START] ? {1'b0, guard_ms} : disc_ms;
                        end else if (cmd && call_cmd == CALL_FAR_ANSWER && !inc) begin
                            st <= CH_ANSWERED; // [R12]
                        end
                    end
                    // cpe reverting to connected is not looked at here
                    CH_FAR_DISC: if (tmr == 12'h0) begin
                        st <= end_state; // [R13]
                        tmr <= {1'b0, guard_ms};
                    end
                endcase
            end
        end

        always_comb begin
            tx_code_v[g] = codes[IDLE_TX]; // [R3]
            hook_v[g] = 1'b0;
            unique case (st)
                CH_IDLE, CH_GUARD: tx_code_v[g] = codes[IDLE_TX]; // [R3]
                CH_BLOCKED: hook_v[g] = ctrl[CTRL_BLK_OFFHOOK]; // [R5]
                CH_RING: tx_code_v[g] = codes[ring_on ? RING_ON_TX : RING_OFF_TX]; // [R6]
                CH_INC_CONN: begin
                    tx_code_v[g] = codes[INC_CONN_TX]; // [R7]
                    hook_v[g] = 1'b1;
                end
                CH_SEIZED: begin
                    if (ctrl[CTRL_SEIZE_ACK_EN]) tx_code_v[g] = codes[SEIZE_ACK_TX]; // [R10]
                    hook_v[g] = !brk; // [R11]
                end
                CH_ANSWERED: begin
                    tx_code_v[g] = codes[ANSWERED_TX]; // [R12]
                    hook_v[g] = 1'b1;
                end
                CH_FAR_DISC: tx_code_v[g] = codes[inc ? INC_FDISC_TX : OUT_FDISC_TX]; // [R8]
            endcase
        end
    end

    // one channel's code is presented per cycle, round robin
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tx_chan <= '0;
            tx_sig <= '0;
            switch_offhook <= '0;
        end else begin
            tx_chan <= (tx_chan == 5'(CHANNELS - 1)) ? 5'h00 : tx_chan + 5'h01;
            tx_sig <= '{chan: tx_chan, code: tx_code_v[tx_chan]};
            switch_offhook <= hook_v;
        end
    end

    // ----
    // line condition detection
    // ----
    logic [1:0] err_run;
    logic [7:0] zero_run, ones_run;
    logic ais;
    logic [1:0] long_v;
    logic [10:0] clean_ms;

    assign ais = oof && ones_run == LOS_ZERO_BITS; // [R19]

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            err_run <= '0;
            oof <= 1'b0;
            reframe_start <= 1'b0;
        end else begin
            reframe_start <= 1'b0;
            if (frame_found) oof <= 1'b0;
            if (fbit_valid) begin
                if (!fbit_error) err_run <= '0;
                else if (err_run != OOF_ERR_BITS - 2'd1) err_run <= err_run + 2'd1;
                else begin
                    oof <= 1'b1; // [R16]
                    reframe_start <= !oof; // [R16]
                end
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            zero_run <= '0;
            ones_run <= '0;
            los <= 1'b0;
            resync_start <= 1'b0;
        end else begin
            resync_start <= 1'b0;
            if (line_bit_valid) begin
                if (line_bit) begin
                    zero_run <= '0;
                    los <= 1'b0;
                    if (ones_run != LOS_ZERO_BITS) ones_run <= ones_run + 8'h01;
                end else begin
                    ones_run <= '0;
                    if (zero_run != LOS_ZERO_BITS) zero_run <= zero_run + 8'h01;
                    if (zero_run == LOS_ZERO_BITS - 8'h01) begin
                        los <= 1'b1; // [R17]
                        resync_start <= 1'b1; // [R17]
                    end
                end
            end
        end
    end

    // persistence timers for loss of signal and AIS
    for (genvar k = 0; k < 2; k++) begin : g_persist
        logic [10:0] ms;
        logic cond;
        assign cond = (k == 0) ? los : ais;
        assign long_v[k] = ms == ALARM_HOLD_MS;
        always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) ms <= '0;
            else if (!cond) ms <= '0;
            else if (ms_tick && ms != ALARM_HOLD_MS) ms <= ms + 11'h001; // [R18] [R19]
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            clean_ms <= '0;
            line_alarm <= 1'b0;
        end else begin
            if (los || oof || ais) clean_ms <= '0;
            else if (ms_tick && clean_ms != ALARM_HOLD_MS) clean_ms <= clean_ms + 11'h001;
            if (|long_v) line_alarm <= 1'b1; // [R18] [R19]
            else if (clean_ms == ALARM_HOLD_MS) line_alarm <= 1'b0; // [R20]
        end
    end

    // ----
    // alarm level, outputs and log
    // ----
    logic [1:0] raise_lvl;
    logic [6:0] log_ptr;
    logic log_we;
    log_kind_t log_kind;

    always_comb begin
        raise_lvl = 2'd0;
        if (ber_level1) raise_lvl = 2'd1; // [R21]
        if (line_alarm || oof || slip_alarm || ber_level2) raise_lvl = 2'd2; // [R21]
    end

    assign log_we = (raise_lvl > alarm_lvl) || clear_alarm;
    assign log_kind = (raise_lvl > alarm_lvl)
        ? ((raise_lvl == 2'd2) ? LOG_LEVEL2 : LOG_LEVEL1) : LOG_CLEARED; // [R23]

    // a rise beats a clear
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) alarm_lvl <= 2'd0;
        else if (raise_lvl > alarm_lvl) alarm_lvl <= raise_lvl;
        else if (clear_alarm) alarm_lvl <= raise_lvl; // [R23]
        else if (ctrl[CTRL_SELF_CLEAR]) alarm_lvl <= raise_lvl; // [R25]
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            alarm_contact <= 1'b0;
            maintenance_indicator <= 1'b0;
            yellow_alarm <= 1'b0;
            line_processing <= 1'b0;
            rx_silence <= 1'b0;
        end else begin
            alarm_contact <= ctrl[CTRL_ALARM_EN] && alarm_lvl != 2'd0; // [R22]
            maintenance_indicator <= !ctrl[CTRL_ALARM_EN] || alarm_lvl != 2'd0; // [R22]
            yellow_alarm <= ctrl[CTRL_ALARM_EN] && alarm_lvl == 2'd2; // [R22]
            line_processing <= ctrl[CTRL_ALARM_EN] && alarm_lvl == 2'd2; // [R22] [R23]
            rx_silence <= oof || line_alarm; // [R16] [R18]
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) seconds <= '0;
        else if (wr_pend && wr_addr == ADDR_TIME) seconds <= hwdata[23:0];
        else if (sec_tick) seconds <= seconds + 24'h000001;
    end

    // wraps over the oldest entry
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            log_ptr <= '0;
            log_count <= '0;
        end else if (clear_log) begin
            log_ptr <= '0; // [R24]
            log_count <= '0;
        end else if (log_we) begin
            log_ptr <= (log_ptr == 7'(LOG_DEPTH - 1)) ? 7'h00 : log_ptr + 7'h01;
            if (log_count != 7'(LOG_DEPTH)) log_count <= log_count + 7'h01; // [R24]
        end
    end

    always_ff @(posedge clock) begin
        if (log_we && !clear_log) log_mem[log_ptr] <= '{kind: log_kind, stamp: seconds};
    end
endmodule // e1_cas_signaling_alarm
`default_nettype wire
